// file: rtl/secmem_port_pkg.sv
// constants, states and state records of the secure memory serial port
package secmem_port_pkg;

	// ----------------------------------------------------------------
	// character timing
	// ----------------------------------------------------------------
	localparam int             ETU_CARRIERS = 372;
	localparam int             ETU_W        = 9;
	localparam logic [ETU_W-1:0] ETU_LAST   = ETU_W'(ETU_CARRIERS - 1);
	localparam logic [ETU_W-1:0] ETU_MID    = ETU_W'(ETU_CARRIERS / 2);

	// ----------------------------------------------------------------
	// bit positions within a character or a byte, answer counts, widths, pipe reset value
	// ----------------------------------------------------------------
	localparam logic [3:0] BIT_START  = 4'h0;
	localparam logic [3:0] BIT_PAR    = 4'h9;
	localparam logic [3:0] BIT_GUARD1 = 4'hA;
	localparam logic [3:0] BIT_GUARD2 = 4'hB;
	localparam logic [3:0] BIT_LAST   = 4'h7;
	localparam logic [3:0] BYTE_FULL  = 4'h8;
	localparam logic [3:0] ATR_WAIT   = 4'h2;
	localparam logic [2:0] ATR_LAST   = 3'h7;
	localparam int         ATR_W      = 64;
	localparam int         ADDR_W     = 4;
	localparam logic [2:0] PIPE_IDLE  = 3'h7;

	// ----------------------------------------------------------------
	// port states, two-wire first, then character mode
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_WRX, S_ACK, S_RTX, S_RACK, S_RNEXT,
		A_HOLD, A_ATR, A_TX, A_IDLE, A_RX
	} port_st_t;

	// ----------------------------------------------------------------
	// state records of both clock domains
	// ----------------------------------------------------------------
	typedef struct packed {
		port_st_t         state;
		logic             async;
		logic             standby;
		logic             reading;
		logic             atr_phase;
		logic             err;
		logic             nak;
		logic [7:0]       sh;
		logic [3:0]       bit_cnt;
		logic [ETU_W-1:0] etu_cnt;
		logic [2:0]       byte_cnt;
		logic             sda_o;
		logic             sda_oe;
		logic [7:0]       rx_byte;
		logic             rx_valid;
		logic             rx_cmd;
		logic             tx_take;
		logic [2:0]       scl_p;
		logic [2:0]       sda_p;
		logic [2:0]       rst_p;
		logic [2:0]       tk_p;
	} core_st_t;

	typedef struct packed {
		logic [1:0] rst_p;
		logic       tgl;
	} link_st_t;

	localparam core_st_t CORE_RESET = '{state: S_IDLE, scl_p: PIPE_IDLE,
		sda_p: PIPE_IDLE, rst_p: PIPE_IDLE, default: '0};

endpackage

// file: rtl/secmem_serial_port.sv
// dual mode serial front end: character protocol and two-wire bus
`timescale 1ns/10ps

// Behaviour
// - one character bit lasts 372 carrier periods
// - character mode runs parity-checked half-duplex exchange
// - two-wire writes sampled at clock rise
// - two-wire read data changes at clock fall
// - reset activation sends eight reset-answer bytes
// - reset pin idles high, giving two-wire mode
// - no reset answer in two-wire mode
// - data pin only pulled low or released
// - respond only to own configured address
// - start condition detected, restarts command
// - stop after read enters standby
// - acknowledge each received byte on ninth clock
module secmem_serial_port
	import secmem_port_pkg::*;
(
	input  wire logic              core_clk_i,   // system clock
	input  wire logic              rst_i,        // sync reset, high
	input  wire logic              ce_i,         // clock enable
	input  wire logic              link_clk_i,   // carrier / serial clock
	input  wire logic              scl_i,        // serial clock pin level
	input  wire logic              sda_i,        // data pin level
	output logic                   sda_o,        // data pin drive value
	output logic                   sda_oe_o,     // data pin pulled low
	input  wire logic              card_rst_i,   // reset pin level
	input  wire logic [ADDR_W-1:0] dev_addr_i,   // own bus address
	input  wire logic [ATR_W-1:0]  atr_i,        // reset answer bytes
	input  wire logic [7:0]        tx_byte_i,    // byte to send
	input  wire logic              tx_valid_i,   // char mode byte ready
	output logic                   tx_take_o,    // tx byte consumed
	output logic [7:0]             rx_byte_o,    // received byte
	output logic                   rx_valid_o,   // received byte pulse
	output logic                   rx_cmd_o,     // byte was command
	output logic                   mode_async_o, // character mode on
	output logic                   standby_o     // standby after read
);

	// ----------------------------------------------------------------
	// state and decoded pin events
	// ----------------------------------------------------------------
	core_st_t q;
	core_st_t n;
	link_st_t l;
	link_st_t nl;

	logic scl_s;
	logic sda_s;
	logic rst_s;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic rst_fall;
	logic tick;
	logic etu_end;
	logic etu_mid;
	logic addr_hit;

	// pin pull decision from a state record
	function automatic logic drive_low(input core_st_t s);
		logic d;
		d = 1'b0;
		case (s.state)
			A_TX:
			begin
				if (s.bit_cnt == BIT_START)
					d = 1'b1;
				else if (s.bit_cnt <= BYTE_FULL)
					d = ~s.sh[s.bit_cnt[2:0] - 3'h1];
				else if (s.bit_cnt == BIT_PAR)
					d = ~(^s.sh);
			end
			A_RX:    d = s.nak;
			S_ACK:   d = 1'b1;
			S_RTX:   d = ~s.sh[7];
			default: d = 1'b0;
		endcase
		return d;
	endfunction

	// second synchroniser stage and its delayed copy feed the decode
	assign scl_s    = q.scl_p[1];
	assign sda_s    = q.sda_p[1];
	assign rst_s    = q.rst_p[1];
	assign scl_rise = scl_s & ~q.scl_p[2];
	assign scl_fall = ~scl_s & q.scl_p[2];
	assign start_c  = scl_s & q.scl_p[2] & ~sda_s & q.sda_p[2];
	assign stop_c   = scl_s & q.scl_p[2] & sda_s & ~q.sda_p[2];
	assign rst_fall = ~rst_s & q.rst_p[2];
	assign tick     = q.tk_p[1] ^ q.tk_p[2];
	assign etu_end  = tick && (q.etu_cnt == ETU_LAST);
	assign etu_mid  = tick && (q.etu_cnt == ETU_MID);
	assign addr_hit = (q.sh[7:4] == dev_addr_i);

	// ----------------------------------------------------------------
	// link side: carrier period toggle
	// ----------------------------------------------------------------
	// one toggle per carrier period, counted on the core side
	always_comb
	begin
		nl       = l;
		nl.rst_p = {l.rst_p[0], rst_i};
		nl.tgl   = l.rst_p[1] ? 1'b0 : ~l.tgl;
	end

	always_ff @(posedge link_clk_i)
	begin
		l <= nl;
	end

	// ----------------------------------------------------------------
	// core side: both protocols
	// ----------------------------------------------------------------
	// next state of the port
	always_comb
	begin
		n          = q;
		n.scl_p    = {q.scl_p[1:0], scl_i};
		n.sda_p    = {q.sda_p[1:0], sda_i};
		n.rst_p    = {q.rst_p[1:0], card_rst_i};
		n.tk_p     = {q.tk_p[1:0], l.tgl};
		n.rx_valid = 1'b0;
		n.tx_take  = 1'b0;
		n.sda_o    = 1'b0;
		if (tick)
			n.etu_cnt = etu_end ? '0 : q.etu_cnt + 1'b1;
		if (q.async)
		begin
			if (!rst_s)
				n.state = A_HOLD;
			else
			begin
				unique case (q.state)
					A_HOLD:
					begin
						n.state    = A_ATR;
						n.bit_cnt  = '0;
						n.etu_cnt  = '0;
						n.byte_cnt = '0;
					end
					A_ATR:
					begin
						if (etu_end)
							n.bit_cnt = q.bit_cnt + 1'b1;
						if (etu_end && q.bit_cnt == ATR_WAIT)
						begin
							n.sh        = atr_i[8 * q.byte_cnt +: 8];
							n.atr_phase = 1'b1;
							n.err       = 1'b0;
							n.bit_cnt   = BIT_START;
							n.state     = A_TX;
						end
					end
					A_TX:
					begin
						// receiver flags a parity fault in the guard time
						if (etu_mid && q.bit_cnt == BIT_GUARD1 && !sda_s)
							n.err = 1'b1;
						if (etu_end)
						begin
							n.bit_cnt = q.bit_cnt + 1'b1;
							if (q.bit_cnt == BIT_GUARD2)
							begin
								n.bit_cnt = BIT_START;
								n.err     = 1'b0;
								if (q.err)
									n.state = A_TX;
								else if (q.atr_phase &&
									q.byte_cnt != ATR_LAST)
								begin
									n.byte_cnt = q.byte_cnt + 1'b1;
									n.sh = atr_i[8 * n.byte_cnt +: 8];
								end
								else
								begin
									n.atr_phase = 1'b0;
									n.state     = A_IDLE;
								end
							end
						end
					end
					A_IDLE:
					begin
						n.bit_cnt = BIT_START;
						n.err     = 1'b0;
						n.nak     = 1'b0;
						if (!sda_s)
						begin
							n.state   = A_RX;
							n.etu_cnt = '0;
						end
						else if (tx_valid_i)
						begin
							n.sh      = tx_byte_i;
							n.tx_take = 1'b1;
							n.etu_cnt = '0;
							n.state   = A_TX;
						end
					end
					A_RX:
					begin
						if (etu_mid)
						begin
							if (q.bit_cnt == BIT_START && sda_s)
								n.state = A_IDLE;
							else if (q.bit_cnt >= 4'h1 &&
								q.bit_cnt <= BYTE_FULL)
								n.sh = {sda_s, q.sh[7:1]};
							else if (q.bit_cnt == BIT_PAR)
							begin
								if (sda_s != ^q.sh)
									n.err = 1'b1;
								else
								begin
									n.rx_byte  = q.sh;
									n.rx_cmd   = 1'b0;
									n.rx_valid = 1'b1;
								end
							end
							else if (q.bit_cnt == BIT_GUARD1)
								n.nak = q.err;
							else if (q.bit_cnt == BIT_GUARD2)
								n.nak = 1'b0;
						end
						if (etu_end)
						begin
							n.bit_cnt = q.bit_cnt + 1'b1;
							if (q.bit_cnt == BIT_GUARD2)
								n.state = A_IDLE;
						end
					end
					default: n.state = A_HOLD;
				endcase
			end
		end
		else if (rst_fall)
		begin
			n.async   = 1'b1;
			n.state   = A_HOLD;
			n.standby = 1'b0;
		end
		else if (start_c)
		begin
			n.state   = S_ADDR;
			n.bit_cnt = '0;
			n.reading = 1'b0;
			n.standby = 1'b0;
		end
		else if (stop_c)
		begin
			n.standby = q.reading;
			n.reading = 1'b0;
			n.state   = S_IDLE;
		end
		else
		begin
			unique case (q.state)
				S_IDLE: n.state = S_IDLE;
				S_ADDR, S_WRX:
				begin
					if (scl_rise && q.bit_cnt < BYTE_FULL)
					begin
						n.sh      = {q.sh[6:0], sda_s};
						n.bit_cnt = q.bit_cnt + 1'b1;
					end
					if (scl_rise && q.bit_cnt == BIT_LAST)
					begin
						n.rx_byte  = n.sh;
						n.rx_cmd   = (q.state == S_ADDR);
						n.rx_valid = (q.state == S_WRX) ||
							(n.sh[7:4] == dev_addr_i);
					end
					if (scl_fall && q.bit_cnt == BYTE_FULL)
					begin
						if (q.state == S_WRX || addr_hit)
							n.state = S_ACK;
						else
							n.state = S_IDLE;
						if (q.state == S_ADDR && addr_hit)
							n.reading = q.sh[0];
					end
				end
				S_ACK:
				begin
					if (scl_fall)
					begin
						n.bit_cnt = '0;
						if (q.reading)
						begin
							n.sh      = tx_byte_i;
							n.tx_take = 1'b1;
							n.state   = S_RTX;
						end
						else
							n.state = S_WRX;
					end
				end
				S_RTX:
				begin
					if (scl_fall)
					begin
						if (q.bit_cnt == BIT_LAST)
							n.state = S_RACK;
						else
						begin
							n.sh      = {q.sh[6:0], 1'b0};
							n.bit_cnt = q.bit_cnt + 1'b1;
						end
					end
				end
				S_RACK:
				begin
					if (scl_rise)
						n.state = sda_s ? S_IDLE : S_RNEXT;
				end
				S_RNEXT:
				begin
					if (scl_fall)
					begin
						n.sh      = tx_byte_i;
						n.tx_take = 1'b1;
						n.bit_cnt = '0;
						n.state   = S_RTX;
					end
				end
				default: n.state = S_IDLE;
			endcase
		end
		n.sda_oe = drive_low(n);
	end

	// register the record, frozen while the enable is low and reset is not asserted
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			q <= CORE_RESET;
		else if (ce_i)
			q <= n;
	end

	// outputs straight from the record
	assign sda_o        = q.sda_o;
	assign sda_oe_o     = q.sda_oe;
	assign tx_take_o    = q.tx_take;
	assign rx_byte_o    = q.rx_byte;
	assign rx_valid_o   = q.rx_valid;
	assign rx_cmd_o     = q.rx_cmd;
	assign mode_async_o = q.async;
	assign standby_o    = q.standby;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	chk_etu_length: assert property (
		(q.state == A_TX && $past(q.state) == A_TX &&
		 q.bit_cnt != $past(q.bit_cnt)) |-> $past(q.etu_cnt) == ETU_LAST)
		else $error("character bit did not last one full unit");

	chk_char_parity: assert property (
		(q.state == A_TX && q.bit_cnt == BIT_PAR) |-> q.sda_oe == ~(^q.sh))
		else $error("parity bit level wrong");

	chk_sample_rise: assert property (
		(ce_i && q.state == S_WRX && scl_rise && q.bit_cnt < BYTE_FULL &&
		 !start_c && !stop_c && !rst_fall) |=> q.sh[0] == $past(sda_s))
		else $error("write bit not sampled at clock rise");

	chk_drive_fall: assert property (
		(q.state == S_RTX && $past(q.state) == S_RTX &&
		 q.sda_oe != $past(q.sda_oe)) |-> $past(scl_fall))
		else $error("read data changed away from clock fall");

	chk_atr_bytes: assert property (
		(q.state == A_TX && q.atr_phase) |->
		q.sh == atr_i[8 * q.byte_cnt +: 8])
		else $error("reset answer byte mismatch");

	chk_no_atr_sync: assert property (
		!q.async |-> (!q.atr_phase && q.state inside {S_IDLE, S_ADDR,
		S_WRX, S_ACK, S_RTX, S_RACK, S_RNEXT}))
		else $error("reset answer active in two-wire mode");

	chk_open_drain: assert property (
		(q.sda_o == 1'b0) && (q.sda_oe == drive_low(q)))
		else $error("data pin driven high or drive inconsistent");

	chk_addr_match: assert property (
		(q.state == S_ACK && $past(q.state) == S_ADDR) |->
		q.sh[7:4] == dev_addr_i)
		else $error("acknowledged a foreign address");

	chk_start_seen: assert property (
		(ce_i && !q.async && !rst_fall && start_c) |=>
		(q.state == S_ADDR && q.bit_cnt == '0))
		else $error("start condition missed");

	chk_read_standby: assert property (
		(ce_i && !q.async && !rst_fall && !start_c && stop_c && q.reading)
		|=> q.standby)
		else $error("no standby after read and stop");

	chk_ack_ninth: assert property (
		(q.state == S_ACK) |-> q.sda_oe && ($past(q.state) == S_ACK ||
		(!scl_s && $past(q.bit_cnt) == BYTE_FULL)))
		else $error("acknowledge not driven on ninth clock");

	chk_async_entry: assert property (
		$rose(q.async) |-> ($past(rst_fall) && q.state == A_HOLD))
		else $error("character mode entered without reset activation");

	chk_idle_release: assert property (
		(q.state inside {S_IDLE, A_IDLE, A_HOLD, A_ATR}) |-> !q.sda_oe)
		else $error("data pin pulled while idle");

	cov_atr_done: cover property (
		q.atr_phase && q.byte_cnt == ATR_LAST ##1 !q.atr_phase);
	cov_write_ack: cover property (
		q.state == S_ACK && !q.reading ##1 q.state == S_WRX);
	cov_read_byte: cover property (q.state == S_RTX ##1 q.state == S_RACK);
	cov_parity_nak: cover property (q.state == A_RX && q.nak);

endmodule // secmem_serial_port

// file: tb/twi_host_model.sv
// two-wire bus host and reset pin driver facing the serial port
`timescale 1ns/10ps
module twi_host_model
(
	input  wire logic clk_i,      // bench clock
	input  wire logic sda_i,      // resolved data wire
	output logic      scl_o,      // serial clock
	output logic      sda_low_o,  // host pulls data low
	output logic      card_rst_o  // reset pin level
);
	// ---------------------------------------------------------
	// idle pins: clock high, data released, reset pulled up
	// ---------------------------------------------------------
	initial
	begin
		scl_o      = 1'b1;
		sda_low_o  = 1'b0;
		card_rst_o = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic set_rst(input logic v);
		card_rst_o <= v;
	endtask

	// one clock: data set while low, wire sampled late in high
	task automatic bit_xfer(input logic b, output logic r);
		tick(4);
		sda_low_o <= ~b;
		tick(4);
		scl_o <= 1'b1;
		tick(8);
		r = sda_i;
		scl_o <= 1'b0;
	endtask

	// data falls while clock high
	task automatic start();
		tick(4);
		sda_low_o <= 1'b0;
		tick(4);
		scl_o <= 1'b1;
		tick(8);
		sda_low_o <= 1'b1;
		tick(8);
		scl_o <= 1'b0;
	endtask

	// data rises while clock high
	task automatic stop();
		tick(4);
		sda_low_o <= 1'b1;
		tick(4);
		scl_o <= 1'b1;
		tick(8);
		sda_low_o <= 1'b0;
		tick(8);
	endtask

	// msb first, ninth clock returns the acknowledge level
	task automatic byte_wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_xfer(d[i], r);
		bit_xfer(1'b1, ack);
	endtask

	task automatic byte_rd(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_xfer(1'b1, d[i]);
		bit_xfer(mack, r);
	endtask
endmodule // twi_host_model

// file: tb/secmem_serial_port_tb.sv
// self-checking bench of the dual mode serial port
`timescale 1ns/10ps
module secmem_serial_port_tb;
	import secmem_port_pkg::*;

	localparam logic [3:0]  ADDR = 4'h9;
	localparam logic [63:0] ATR  = 64'h0123_4567_89AB_CD3B;
	localparam logic [7:0]  TX   = 8'hC5;
	localparam int          UNIT = ETU_CARRIERS * 16;

	logic       core_clk = 1'b0;
	logic       rst      = 1'b1;
	logic       link_clk = 1'b0;
	logic       link_run = 1'b0;
	logic       scl;
	logic       sda_low;
	logic       card_rst;
	wire logic  sda;
	logic       sda_o, sda_oe_o, tx_take_o, rx_valid_o;
	logic       rx_cmd_o, mode_async_o, standby_o;
	logic [7:0] rx_byte_o;
	logic [7:0] rx_seen  = 8'h00;
	logic       cmd_seen = 1'b0;
	int         rx_cnt   = 0;
	int         take_cnt = 0;
	int         checked  = 0;
	int         bad_count = 0;

	// ---------------------------------------------------------
	// clocks, wired-and data line, design and host
	// ---------------------------------------------------------
	always #5 core_clk = ~core_clk;
	always #80 if (link_run) link_clk = ~link_clk;
	assign sda = ~(sda_low | sda_oe_o);

	secmem_serial_port i_secmem_serial_port (
		.core_clk_i(core_clk), .rst_i(rst), .ce_i(1'b1),
		.link_clk_i(link_clk), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .card_rst_i(card_rst),
		.dev_addr_i(ADDR), .atr_i(ATR), .tx_byte_i(TX),
		.tx_valid_i(1'b0), .tx_take_o(tx_take_o),
		.rx_byte_o(rx_byte_o), .rx_valid_o(rx_valid_o),
		.rx_cmd_o(rx_cmd_o), .mode_async_o(mode_async_o),
		.standby_o(standby_o));

	twi_host_model i_twi_host_model (
		.clk_i(core_clk), .sda_i(sda), .scl_o(scl),
		.sda_low_o(sda_low), .card_rst_o(card_rst));

	// one-cycle receive and take pulses caught here
	always @(posedge core_clk)
	begin
		if (rx_valid_o === 1'b1)
		begin
			rx_seen  <= rx_byte_o;
			cmd_seen <= rx_cmd_o;
			rx_cnt   <= rx_cnt + 1;
		end
		if (tx_take_o === 1'b1)
			take_cnt <= take_cnt + 1;
	end

	// ---------------------------------------------------------
	// helpers
	// ---------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// bounded wait for the drive enable to reach a level
	task automatic wait_oe(input logic lvl, input int lim, output int n);
		n = 0;
		while (sda_oe_o !== lvl)
		begin
			if (n == lim)
			begin
				check("wait for drive", 1'b0, 1'b1);
				final_report();
			end
			tick(1);
			n++;
		end
	endtask

	// ---------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------
	task automatic t_reset_idle();
		check("mode after reset", mode_async_o, 1'b0);
		check("drive after reset", sda_oe_o, 1'b0);
		check("standby after reset", standby_o, 1'b0);
	endtask

	task automatic t_write();
		logic a;
		int   c0;
		c0 = rx_cnt;
		i_twi_host_model.start();
		i_twi_host_model.byte_wr({ADDR, 3'h5, 1'b0}, a);
		check("address ack", a, 1'b0);
		check("drive value", sda_o, 1'b0);
		check("command byte", {cmd_seen, rx_seen}, {1'b1, ADDR, 4'hA});
		i_twi_host_model.byte_wr(8'hA6, a);
		check("data ack", a, 1'b0);
		check("data byte", {cmd_seen, rx_seen}, 9'h0A6);
		check("byte count", rx_cnt - c0, 2);
		i_twi_host_model.stop();
	endtask

	task automatic t_foreign();
		logic a;
		int   c0;
		c0 = rx_cnt;
		i_twi_host_model.start();
		i_twi_host_model.byte_wr({ADDR ^ 4'h5, 3'h5, 1'b0}, a);
		check("foreign ack", a, 1'b1);
		i_twi_host_model.byte_wr(8'h00, a);
		check("ignored data ack", a, 1'b1);
		check("foreign count", rx_cnt - c0, 0);
		i_twi_host_model.stop();
	endtask

	task automatic t_read();
		logic       a;
		logic [7:0] d;
		int         t0;
		t0 = take_cnt;
		i_twi_host_model.start();
		i_twi_host_model.byte_wr({ADDR, 3'h2, 1'b1}, a);
		check("read address ack", a, 1'b0);
		// host acks the first byte, so a second one follows
		i_twi_host_model.byte_rd(1'b0, d);
		check("read byte", d, TX);
		i_twi_host_model.byte_rd(1'b1, d);
		check("second read byte", d, TX);
		check("bytes taken", take_cnt - t0, 2);
		i_twi_host_model.stop();
		tick(8);
		check("standby after read", standby_o, 1'b1);
		check("no char mode", mode_async_o, 1'b0);
		// partial byte cut short by a new start
		i_twi_host_model.start();
		repeat (3) i_twi_host_model.bit_xfer(1'b0, a);
		i_twi_host_model.start();
		i_twi_host_model.byte_wr({ADDR, 3'h5, 1'b0}, a);
		check("restart ack", a, 1'b0);
		check("standby cleared", standby_o, 1'b0);
		i_twi_host_model.stop();
	endtask

	// reset pin activation, then the first answer character
	task automatic t_char_mode();
		int         n;
		logic [9:0] frame;
		frame = {^ATR[7:0], ATR[7:0], 1'b0};
		link_run = 1'b1;
		rst <= 1'b1;
		tick(60);
		rst <= 1'b0;
		tick(10);
		i_twi_host_model.set_rst(1'b0);
		tick(20);
		check("char mode entered", mode_async_o, 1'b1);
		check("quiet before answer", sda_oe_o, 1'b0);
		i_twi_host_model.set_rst(1'b1);
		// first start bit three units after the reset pin rises
		wait_oe(1'b1, 4 * UNIT, n);
		check("answer delay", n >= 3 * UNIT - 24 &&
			n <= 3 * UNIT + 24, 1);
		tick(UNIT / 2);
		for (int k = 0; k < 10; k++)
		begin
			check("answer bit", sda, frame[k]);
			tick(UNIT);
		end
	endtask

	// ---------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------
	initial
	begin
		tick(20);
		rst <= 1'b0;
		tick(4);
		t_reset_idle();
		t_write();
		t_foreign();
		t_read();
		t_char_mode();
		final_report();
	end
endmodule // secmem_serial_port_tb
